// ==== pkg/eil_params.svh ====
`ifndef EIL_PARAMS_SVH
`define EIL_PARAMS_SVH

// Register byte offsets.
`define EIL_OFS_STATUS_CTRL 4'h0
`define EIL_OFS_LATCH_STATE 4'h4
`define EIL_OFS_BREAK_CTRL 4'h8

// Field positions in ext_int_status_ctrl.
`define EIL_BIT_SENSE_SEL_A 0
`define EIL_BIT_REQ_MASK_A 1
`define EIL_BIT_ACK_A 2
`define EIL_BIT_SENSE_SEL_B 3
`define EIL_BIT_REQ_MASK_B 4
`define EIL_BIT_ACK_B 5
`define EIL_BIT_LATCH_DISABLE_B 6
`define EIL_BIT_PIN_LEVEL_B 7

// Field positions in the latch state register.
`define EIL_BIT_LATCH_A 0
`define EIL_BIT_LATCH_B 1
`define EIL_BIT_PIN_LEVEL_A 2

// Field position in the break control register.
`define EIL_BIT_BREAK_FLAG_CLEAR_EN 0

// Reset values.
`define EIL_RST_CTRL_BIT 1'b0
`define EIL_RST_PIN_SYNC 1'b1
`define EIL_RST_DATA 32'h0000_0000

// Bus response codes.
`define EIL_RESP_OKAY 2'h0
`define EIL_RESP_SLVERR 2'h2

`endif

// ==== pkg/eil_pkg.sv ====
package eil_pkg;

  typedef logic [1:0] eil_resp_t;

  typedef logic [31:0] eil_word_t;

  typedef enum logic
  {
    EIL_EDGE_ONLY,
    EIL_EDGE_AND_LEVEL
  } eil_sense_t;

endpackage : eil_pkg

// ==== hdl/eil_edge_latch.sv ====
`timescale 1ns/1ps
`include "eil_params.svh"

module eil_edge_latch
  import eil_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_pin_n,
  input wire eil_sense_t i_sense,
  input wire logic i_latch_dis,
  input wire logic i_ack,
  output logic o_latch,
  output logic o_level
);

  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic latch_q;
  logic ack_seen_q;
  logic fall;
  logic low;
  logic level_mode;

  // Two stages before anything reads the pin; the first stage feeds only the second.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      meta_q <= `EIL_RST_PIN_SYNC;
      sync_q <= `EIL_RST_PIN_SYNC;
      prev_q <= `EIL_RST_PIN_SYNC;
    end
    else
    begin
      meta_q <= i_pin_n;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_mode = (i_sense == EIL_EDGE_AND_LEVEL);
  assign fall = prev_q & ~sync_q & ~i_latch_dis;
  assign low = ~sync_q & level_mode & ~i_latch_dis;

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      latch_q <= 1'b0;
    end
    else if (fall)
    begin
      latch_q <= 1'b1;
    end
    else if (level_mode)
    begin
      if ((i_ack | ack_seen_q) & sync_q)
      begin
        latch_q <= 1'b0;
      end
      else if (low)
      begin
        latch_q <= 1'b1;
      end
    end
    else if (i_ack)
    begin
      latch_q <= 1'b0;
    end
  end

  // Remembers an acknowledge taken while the pin was still low.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      ack_seen_q <= 1'b0;
    end
    else
    begin
      ack_seen_q <= level_mode & latch_q & ~fall & ~sync_q & (i_ack | ack_seen_q);
    end
  end

  assign o_latch = latch_q;
  assign o_level = sync_q;

endmodule : eil_edge_latch

// ==== hdl/eil_top.sv ====
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "eil_params.svh"

// How it works
// - A low level on either external pin can set an interrupt request latch.
// - Pin a sets only latch a; pin b sets only latch b.
// - A vector fetch acknowledge clears only the latch that caused it.
// - Writing one to ack_a clears latch a.
// - Writing one to ack_b clears latch b.
// - Reset clears both request latches.
// - Pins trigger on falling edges by default; edge plus level is selectable.
// - sense_sel_a selects edge-only or edge-plus-level for pin a.
// - sense_sel_b selects the sensitivity of pin b.
// - In edge-only mode a set latch stays set until acknowledge or reset.
// - In edge-plus-level mode clearing needs both an acknowledge and a high pin.
// - The acknowledge may come before or after the pin goes high.
// - A latched request reaches priority logic only while its mask bit is clear.
// - Both acknowledge bits are write-only and read as zero.
// - latch_disable_b stops pin b from latching; reset clears it.
// - In break state with break_flag_clear_enable zero, acknowledge writes do nothing.
// - pin_level_b reads the level of pin b even while latching is disabled.
module eil_top
  import eil_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ext_int_pin_a_n,
  input wire logic i_ext_int_pin_b_n,
  input wire logic i_vec_fetch_ack_a,
  input wire logic i_vec_fetch_ack_b,
  input wire logic i_break_state,
  output logic o_irq_req_a,
  output logic o_irq_req_b,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  eil_resp_t bresp_q;
  logic arready_q;
  logic rvalid_q;
  eil_word_t rdata_q;
  eil_resp_t rresp_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q;
  logic w_have_q;

  eil_sense_t sense_sel_a_q;
  eil_sense_t sense_sel_b_q;
  logic req_mask_a_q;
  logic req_mask_b_q;
  logic latch_disable_b_q;
  logic break_flag_clear_enable_q;
  logic irq_req_a_q;
  logic irq_req_b_q;

  logic wr_fire;
  logic wr_ctrl;
  logic wr_brk;
  logic wr_mapped;
  logic ack_allowed;
  logic sw_ack_a;
  logic sw_ack_b;
  logic ack_a;
  logic ack_b;
  logic latch_a;
  logic latch_b;
  logic pin_level_a;
  logic pin_level_b;
  eil_word_t rd_word;
  logic rd_mapped;

  // Write address and data are taken in either order and held until both are present.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b0;
      awaddr_q <= 4'h0;
    end
    else if (s_axi_awvalid && awready_q)
    begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (wr_fire)
    begin
      aw_have_q <= 1'b0;
    end
    else if (!aw_have_q && !bvalid_q)
    begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      wready_q <= 1'b0;
      w_have_q <= 1'b0;
      wdata_q <= `EIL_RST_DATA;
      wstrb_q <= 4'h0;
    end
    else if (s_axi_wvalid && wready_q)
    begin
      wready_q <= 1'b0;
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (wr_fire)
    begin
      w_have_q <= 1'b0;
    end
    else if (!w_have_q && !bvalid_q)
    begin
      wready_q <= 1'b1;
    end
  end

  assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_ctrl = wr_fire & (awaddr_q == `EIL_OFS_STATUS_CTRL) & wstrb_q[0];
  assign wr_brk = wr_fire & (awaddr_q == `EIL_OFS_BREAK_CTRL) & wstrb_q[0];
  assign wr_mapped = (awaddr_q == `EIL_OFS_STATUS_CTRL)
    || (awaddr_q == `EIL_OFS_LATCH_STATE)
    || (awaddr_q == `EIL_OFS_BREAK_CTRL);

  // Write response follows the register update; unmapped addresses answer SLVERR.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `EIL_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? `EIL_RESP_OKAY : `EIL_RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // Control fields of the status and control register.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      sense_sel_a_q <= EIL_EDGE_ONLY;
      sense_sel_b_q <= EIL_EDGE_ONLY;
      req_mask_a_q <= `EIL_RST_CTRL_BIT;
      req_mask_b_q <= `EIL_RST_CTRL_BIT;
      latch_disable_b_q <= `EIL_RST_CTRL_BIT;
    end
    else if (wr_ctrl)
    begin
      sense_sel_a_q <= eil_sense_t'(wdata_q[`EIL_BIT_SENSE_SEL_A]);
      sense_sel_b_q <= eil_sense_t'(wdata_q[`EIL_BIT_SENSE_SEL_B]);
      req_mask_a_q <= wdata_q[`EIL_BIT_REQ_MASK_A];
      req_mask_b_q <= wdata_q[`EIL_BIT_REQ_MASK_B];
      latch_disable_b_q <= wdata_q[`EIL_BIT_LATCH_DISABLE_B];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      break_flag_clear_enable_q <= `EIL_RST_CTRL_BIT;
    end
    else if (wr_brk)
    begin
      break_flag_clear_enable_q <= wdata_q[`EIL_BIT_BREAK_FLAG_CLEAR_EN];
    end
  end

  // Software acknowledges are pulses, never stored, and are blocked in protected break.
  assign ack_allowed = ~i_break_state | break_flag_clear_enable_q;
  assign sw_ack_a = wr_ctrl & wdata_q[`EIL_BIT_ACK_A] & ack_allowed;
  assign sw_ack_b = wr_ctrl & wdata_q[`EIL_BIT_ACK_B] & ack_allowed;
  assign ack_a = sw_ack_a | i_vec_fetch_ack_a;
  assign ack_b = sw_ack_b | i_vec_fetch_ack_b;

  eil_edge_latch u_latch_a
  (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_pin_n(i_ext_int_pin_a_n),
    .i_sense(sense_sel_a_q),
    .i_latch_dis(1'b0),
    .i_ack(ack_a),
    .o_latch(latch_a),
    .o_level(pin_level_a)
  );

  eil_edge_latch u_latch_b
  (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_pin_n(i_ext_int_pin_b_n),
    .i_sense(sense_sel_b_q),
    .i_latch_dis(latch_disable_b_q),
    .i_ack(ack_b),
    .o_latch(latch_b),
    .o_level(pin_level_b)
  );

  // Masked requests toward the priority logic; the CPU applies its own global mask.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      irq_req_a_q <= 1'b0;
      irq_req_b_q <= 1'b0;
    end
    else
    begin
      irq_req_a_q <= latch_a & ~req_mask_a_q;
      irq_req_b_q <= latch_b & ~req_mask_b_q;
    end
  end

  // Read data mux; acknowledge bit positions always read zero.
  always_comb
  begin
    rd_word = `EIL_RST_DATA;
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      `EIL_OFS_STATUS_CTRL:
      begin
        rd_word[`EIL_BIT_SENSE_SEL_A] = sense_sel_a_q;
        rd_word[`EIL_BIT_REQ_MASK_A] = req_mask_a_q;
        rd_word[`EIL_BIT_ACK_A] = 1'b0;
        rd_word[`EIL_BIT_SENSE_SEL_B] = sense_sel_b_q;
        rd_word[`EIL_BIT_REQ_MASK_B] = req_mask_b_q;
        rd_word[`EIL_BIT_ACK_B] = 1'b0;
        rd_word[`EIL_BIT_LATCH_DISABLE_B] = latch_disable_b_q;
        rd_word[`EIL_BIT_PIN_LEVEL_B] = pin_level_b;
      end
      `EIL_OFS_LATCH_STATE:
      begin
        rd_word[`EIL_BIT_LATCH_A] = latch_a;
        rd_word[`EIL_BIT_LATCH_B] = latch_b;
        rd_word[`EIL_BIT_PIN_LEVEL_A] = pin_level_a;
      end
      `EIL_OFS_BREAK_CTRL:
      begin
        rd_word[`EIL_BIT_BREAK_FLAG_CLEAR_EN] = break_flag_clear_enable_q;
      end
      default:
      begin
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= `EIL_RST_DATA;
      rresp_q <= `EIL_RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_mapped ? `EIL_RESP_OKAY : `EIL_RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
    else if (!rvalid_q)
    begin
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign o_irq_req_a = irq_req_a_q;
  assign o_irq_req_b = irq_req_b_q;

endmodule : eil_top

// ==== test/eil_checker.sv ====
`timescale 1ns/1ps
module eil_checker (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ext_int_pin_a_n,
  input wire logic i_ext_int_pin_b_n,
  input wire logic i_vec_fetch_ack_a,
  input wire logic i_vec_fetch_ack_b,
  input wire logic o_irq_req_a,
  input wire logic o_irq_req_b,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid
);
  logic [3:0] rofs_q;
  logic [3:0] hia_q;
  logic [3:0] hib_q;
  logic [3:0] wage_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_clk)
  begin
    if (s_axi_arvalid && s_axi_arready)
      rofs_q <= s_axi_araddr;
  end
  // Cycles each pin has been high, and cycles since the last register write.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      hia_q <= 4'h0;
      hib_q <= 4'h0;
      wage_q <= 4'h0;
    end
    else
    begin
      hia_q <= i_ext_int_pin_a_n ? hia_q + 4'(hia_q != 4'hf) : 4'h0;
      hib_q <= i_ext_int_pin_b_n ? hib_q + 4'(hib_q != 4'hf) : 4'h0;
      wage_q <= (s_axi_wvalid && s_axi_wready) ? 4'h0 : wage_q + 4'(wage_q != 4'hf);
    end
  end
  a_reset_quiet: assert property ($rose(i_rstn) |-> !o_irq_req_a && !o_irq_req_b)
    else $error("request present after reset");
  a_ack_reads_zero: assert property (s_axi_rvalid && rofs_q == 4'h0 |->
    !s_axi_rdata[2] && !s_axi_rdata[5]) else $error("acknowledge bit read as one");
  a_pin_level_b: assert property ($stable(i_ext_int_pin_b_n)[*6] ##0
    ($rose(s_axi_rvalid) && rofs_q == 4'h0) |-> s_axi_rdata[7] == i_ext_int_pin_b_n)
    else $error("pin b level wrong");
  a_req_latch_a: assert property ($rose(s_axi_rvalid) && rofs_q == 4'h4 && o_irq_req_a
    |-> s_axi_rdata[0]) else $error("request a without latch a");
  a_req_latch_b: assert property ($rose(s_axi_rvalid) && rofs_q == 4'h4 && o_irq_req_b
    |-> s_axi_rdata[1]) else $error("request b without latch b");
  a_fetch_clear_a: assert property (i_vec_fetch_ack_a && hia_q > 4'h8
    |-> ##[1:3] !o_irq_req_a) else $error("fetch did not clear a");
  a_fetch_clear_b: assert property (i_vec_fetch_ack_b && hib_q > 4'h8
    |-> ##[1:3] !o_irq_req_b) else $error("fetch did not clear b");
  a_no_spurious: assert property ($rose(o_irq_req_a) |-> hia_q < 4'h8 || wage_q < 4'h8)
    else $error("request a without cause");
  cover property ($rose(o_irq_req_a));
  cover property ($rose(o_irq_req_b));
  cover property (i_vec_fetch_ack_b && o_irq_req_b);
endmodule : eil_checker

bind eil_top eil_checker i_chk (.i_clk, .i_rstn, .i_ext_int_pin_a_n, .i_ext_int_pin_b_n,
  .i_vec_fetch_ack_a, .i_vec_fetch_ack_b, .o_irq_req_a, .o_irq_req_b, .s_axi_wvalid,
  .s_axi_wready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid);

// ==== test/eil_cpu_model.sv ====
`timescale 1ns/1ps
module eil_cpu_model (
  input wire logic i_clk,
  input wire logic [1:0] i_irq,
  output logic [1:0] o_pin_n,
  output logic [1:0] o_fetch
);
  logic [1:0] pin_n_q = 2'h3;
  logic [1:0] man_q = 2'h0;
  logic [1:0] auto_q = 2'h0;
  logic cpu_on_q = 1'b0;
  logic gmask_q = 1'b0;
  assign o_pin_n = pin_n_q;
  assign o_fetch = man_q | auto_q;
  // The CPU vectors to the highest pending request unless its global mask is set.
  always @(posedge i_clk)
    auto_q <= (cpu_on_q && !gmask_q && auto_q == 2'h0) ?
      (i_irq[0] ? 2'h1 : {i_irq[1], 1'b0}) : 2'h0;
  task automatic fetch(input int k);
    @(posedge i_clk);
    man_q[k] <= 1'b1;
    @(posedge i_clk);
    man_q[k] <= 1'b0;
  endtask : fetch
endmodule : eil_cpu_model

// ==== test/external_interrupt_latches_test.sv ====
`timescale 1ns/1ps
`include "eil_params.svh"
module external_interrupt_latches_test
  import eil_pkg::*;
;
  localparam logic [3:0] sc = `EIL_OFS_STATUS_CTRL;
  localparam logic [3:0] ls = `EIL_OFS_LATCH_STATE;
  localparam logic [3:0] bc = `EIL_OFS_BREAK_CTRL;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic brk = 1'b0;
  logic [1:0] pin_n, ack, irq;
  logic [3:0] aw_a = 4'h0, ar_a = 4'h0;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  eil_word_t w_d = 32'h0, r_d, d;
  eil_resp_t b_rsp, r_rsp, rsp;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #50 i_clk = ~i_clk;
  eil_top i_dut (.i_clk, .i_rstn, .i_ext_int_pin_a_n(pin_n[0]), .i_ext_int_pin_b_n(pin_n[1]),
    .i_vec_fetch_ack_a(ack[0]), .i_vec_fetch_ack_b(ack[1]), .i_break_state(brk),
    .o_irq_req_a(irq[0]), .o_irq_req_b(irq[1]), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_rsp), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_rsp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r));
  eil_cpu_model i_src (.i_clk, .i_irq(irq), .o_pin_n(pin_n), .o_fetch(ack));
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic chk(input eil_word_t g, input eil_word_t e);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tmo(input int n);
    if (n == 50)
    begin
      n_mismatch++;
      $display("Error at %0t: bus timeout", $time);
      stop_test();
    end
  endtask : tmo
  task automatic wr(input logic [3:0] a, input eil_word_t v);
    int n;
    n = 0;
    @(posedge i_clk);
    aw_a <= a;
    w_d <= v;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
    end
    while (!b_v && n < 50);
    b_r <= 1'b0;
    rsp = b_rsp;
    tmo(n);
  endtask : wr
  task automatic rc(input logic [3:0] a, input eil_word_t e);
    int n;
    n = 0;
    @(posedge i_clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
      if (ar_rdy) ar_v <= 1'b0;
    end
    while (!r_v && n < 50);
    r_r <= 1'b0;
    d = r_d;
    rsp = r_rsp;
    tmo(n);
    chk(d, e);
  endtask : rc
  // Pin changes pass two sync stages and the latch, so settle six cycles.
  task automatic pin(input int k, input logic v);
    @(posedge i_clk);
    i_src.pin_n_q[k] <= v;
    repeat (6) @(posedge i_clk);
  endtask : pin
  task automatic look(input logic [1:0] l, input logic [1:0] q);
    rc(ls, {29'h0, i_src.pin_n_q[0], l});
    chk({30'h0, irq}, {30'h0, q});
  endtask : look
  initial
  begin
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clk);
    rc(sc, 32'h80);
    rc(bc, 32'h0);
    rc(4'hc, 32'h0);
    chk(32'(rsp), 32'(`EIL_RESP_SLVERR));
    wr(4'hc, 32'h4);
    chk(32'(rsp), 32'(`EIL_RESP_SLVERR));
    for (int k = 0; k < 2; k++)
    begin
      pin(k, 0);
      pin(k, 1);
      look(2'(1 << k), 2'(1 << k));
      i_src.fetch(1 - k);
      look(2'(1 << k), 2'(1 << k));
      i_src.fetch(k);
      look(2'h0, 2'h0);
      pin(k, 0);
      pin(k, 1);
      wr(sc, k ? 32'h20 : 32'h4);
      look(2'h0, 2'h0);
      rc(sc, 32'h80);
      wr(sc, k ? 32'h18 : 32'h3);
      pin(k, 0);
      look(2'(1 << k), 2'h0);
      wr(sc, k ? 32'h28 : 32'h5);
      look(2'(1 << k), 2'(1 << k));
      pin(k, 1);
      look(2'h0, 2'h0);
      pin(k, 0);
      pin(k, 1);
      look(2'(1 << k), 2'(1 << k));
      wr(sc, k ? 32'h28 : 32'h5);
      look(2'h0, 2'h0);
      wr(sc, 32'h0);
    end
    wr(sc, 32'h40);
    pin(1, 0);
    rc(sc, 32'h40);
    look(2'h0, 2'h0);
    pin(1, 1);
    wr(sc, 32'h0);
    brk <= 1'b1;
    pin(0, 0);
    pin(0, 1);
    wr(sc, 32'h4);
    look(2'h1, 2'h1);
    wr(bc, 32'h1);
    chk(32'(rsp), 32'(`EIL_RESP_OKAY));
    rc(bc, 32'h1);
    wr(sc, 32'h4);
    look(2'h0, 2'h0);
    wr(bc, 32'h0);
    brk <= 1'b0;
    i_src.gmask_q <= 1'b1;
    i_src.cpu_on_q <= 1'b1;
    pin(1, 0);
    pin(1, 1);
    look(2'h2, 2'h2);
    i_src.gmask_q <= 1'b0;
    repeat (6) @(posedge i_clk);
    look(2'h0, 2'h0);
    i_src.cpu_on_q <= 1'b0;
    pin(0, 0);
    pin(0, 1);
    wr(sc, 32'h53);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clk);
    look(2'h0, 2'h0);
    rc(sc, 32'h80);
    stop_test();
  end
endmodule : external_interrupt_latches_test
